// >>> lpm_mode_ctrl.sv
// operating-mode controller: active, standby, stop, watch and subactive
`timescale 1ns/1ps
`default_nettype none
`include "lpm_defs.svh"
module lpm_mode_ctrl #(
  parameter bit SUBACTIVE_EN = 1'b1,
  parameter int unsigned SETTLE_CYCLES = `LPM_SETTLE_CYCLES
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic standby_instr_i,
  input wire logic stop_instr_i,
  input wire logic global_irq_enable_i,
  input wire logic unmasked_irq_pending_i,
  input wire logic irq_request_i,
  input wire logic timer_a_irq_i,
  input wire logic frame_strobe_i,
  input wire logic lcd_on_subclock_i,
  input wire logic ext_irq_zero_pin_n_i,
  input wire logic halt_release_pin_n_i,
  input wire logic [`LPM_ADDR_W-1:0] reg_addr_i,
  input wire logic [`LPM_DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [`LPM_DATA_W-1:0] reg_rdata_o,
  output lpm_pkg::lpm_mode_t mode_o,
  output lpm_pkg::lpm_gate_t gate_o,
  output logic instr_nop_o,
  output logic cpu_restart_o,
  output logic core_state_lost_o,
  output logic ram_valid_flag_o
);
  lpm_pkg::lpm_mode_t state_q;
  lpm_pkg::lpm_mode_t state_d;
  lpm_pkg::lpm_ctrl_t ctrl_q;
  lpm_pkg::lpm_gate_t gate_d;
  logic [1:0] rel_sync_q;
  logic [1:0] ext_irq_zero_pin_sync_q;
  logic ext_irq_zero_pin_sample_q;
  logic ext_irq_zero_pin_armed_q;
  logic from_stop_q;
  logic settle_start;
  logic settle_busy;
  logic settle_done;
  logic sleep_req;
  logic nop_now;
  logic ext_irq_zero_pin_fire;
  logic wake_evt;
  logic release_req;
  logic wake_from_stop;

  // both pins arrive from outside the clock domain
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      rel_sync_q <= 2'h3;
      ext_irq_zero_pin_sync_q <= 2'h3;
    end else if (clk_en_i) begin
      rel_sync_q <= {rel_sync_q[0], halt_release_pin_n_i};
      ext_irq_zero_pin_sync_q <= {ext_irq_zero_pin_sync_q[0], ext_irq_zero_pin_n_i};
    end
  end

  assign release_req = ~rel_sync_q[1];
  assign sleep_req = standby_instr_i | stop_instr_i;
  assign nop_now = sleep_req & ~global_irq_enable_i & unmasked_irq_pending_i;

  // the external interrupt is seen only at frame strobes, so a pulse that spans
  // no strobe is missed; the edge counts from the second strobe after it
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      ext_irq_zero_pin_sample_q <= 1'b1;
      ext_irq_zero_pin_armed_q <= 1'b0;
    end else if (clk_en_i) begin
      if (state_q != lpm_pkg::LPM_WATCH) begin
        ext_irq_zero_pin_sample_q <= ext_irq_zero_pin_sync_q[1];
        ext_irq_zero_pin_armed_q <= 1'b0;
      end else if (frame_strobe_i) begin
        ext_irq_zero_pin_sample_q <= ext_irq_zero_pin_sync_q[1];
        ext_irq_zero_pin_armed_q <= ext_irq_zero_pin_sample_q & ~ext_irq_zero_pin_sync_q[1];
      end
    end
  end

  assign ext_irq_zero_pin_fire = ext_irq_zero_pin_armed_q & frame_strobe_i;
  assign wake_evt = ext_irq_zero_pin_fire | timer_a_irq_i;
  // from_stop_q only rises with the wake edge itself, so the stop state counts too
  assign wake_from_stop = from_stop_q | (state_q == lpm_pkg::LPM_STOP);

  always_comb begin
    state_d = state_q;
    settle_start = 1'b0;
    unique case (state_q)
      lpm_pkg::LPM_ACTIVE: begin
        if (sleep_req & ~nop_now) begin
          if (standby_instr_i) begin
            state_d = lpm_pkg::LPM_STANDBY;
          end else if (ctrl_q.sleep_depth_select) begin
            state_d = lpm_pkg::LPM_WATCH;
          end else begin
            state_d = lpm_pkg::LPM_STOP;
          end
        end
      end
      lpm_pkg::LPM_STANDBY: begin
        if (irq_request_i) begin
          state_d = lpm_pkg::LPM_ACTIVE;
        end
      end
      lpm_pkg::LPM_STOP: begin
        if (release_req) begin
          state_d = lpm_pkg::LPM_WAKE;
          settle_start = 1'b1;
        end
      end
      lpm_pkg::LPM_WATCH: begin
        if (wake_evt) begin
          if (SUBACTIVE_EN && ctrl_q.low_speed_wake_select) begin
            state_d = lpm_pkg::LPM_SUBACTIVE;
          end else begin
            state_d = lpm_pkg::LPM_WAKE;
            settle_start = 1'b1;
          end
        end
      end
      lpm_pkg::LPM_SUBACTIVE: begin
        if (sleep_req & ~nop_now) begin
          if (~ctrl_q.low_speed_wake_select & ctrl_q.direct_wake_select) begin
            state_d = lpm_pkg::LPM_WAKE;
            settle_start = 1'b1;
          end else begin
            state_d = lpm_pkg::LPM_WATCH;
          end
        end
      end
      lpm_pkg::LPM_WAKE: begin
        if (settle_done) begin
          state_d = lpm_pkg::LPM_ACTIVE;
        end
      end
      default: begin
        state_d = lpm_pkg::LPM_ACTIVE;
      end
    endcase
  end

  // reset lands here from any mode, standby included
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= lpm_pkg::LPM_ACTIVE;
    end else if (clk_en_i) begin
      state_q <= state_d;
    end
  end

  lpm_settle_timer #(
    .CYCLES(SETTLE_CYCLES)
  ) u_settle (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .clk_en_i(clk_en_i),
    .start_i(settle_start),
    .busy_o(settle_busy),
    .done_o(settle_done)
  );

  always_comb begin
    gate_d = '0;
    unique case (state_d)
      lpm_pkg::LPM_ACTIVE: begin
        gate_d = '1;
        gate_d.periph_rst = 1'b0;
        gate_d.pins_hiz = 1'b0;
        gate_d.io_hold = 1'b0;
      end
      lpm_pkg::LPM_STANDBY: begin
        gate_d = '1;
        gate_d.cpu_clk = 1'b0;
        gate_d.periph_rst = 1'b0;
        gate_d.pins_hiz = 1'b0;
      end
      lpm_pkg::LPM_STOP: begin
        gate_d.sub_osc = ~ctrl_q.subclock_halt_select;
        gate_d.periph_rst = 1'b1;
        gate_d.pins_hiz = 1'b1;
      end
      lpm_pkg::LPM_WATCH: begin
        gate_d.sub_osc = 1'b1;
        gate_d.timer_a = 1'b1;
        gate_d.lcd = lcd_on_subclock_i;
        gate_d.serial = 1'b1;
        gate_d.io_hold = 1'b1;
      end
      lpm_pkg::LPM_SUBACTIVE: begin
        gate_d = '1;
        gate_d.sys_osc = 1'b0;
        gate_d.adc = 1'b0;
        gate_d.periph_rst = 1'b0;
        gate_d.pins_hiz = 1'b0;
        gate_d.io_hold = 1'b0;
      end
      lpm_pkg::LPM_WAKE: begin
        // both oscillators run; reset, high-z, hold, timer and lcd follow stop, else watch with serial off
        gate_d.sys_osc = 1'b1;
        gate_d.sub_osc = 1'b1;
        gate_d.periph_rst = wake_from_stop;
        gate_d.pins_hiz = wake_from_stop;
        gate_d.io_hold = ~wake_from_stop;
        gate_d.timer_a = ~wake_from_stop;
        gate_d.lcd = ~wake_from_stop & lcd_on_subclock_i;
      end
      default: begin
        gate_d = '0;
      end
    endcase
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      gate_o <= '0;
      mode_o <= lpm_pkg::LPM_ACTIVE;
    end else if (clk_en_i) begin
      gate_o <= gate_d;
      mode_o <= state_d;
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      from_stop_q <= 1'b0;
      ram_valid_flag_o <= 1'b0;
      cpu_restart_o <= 1'b0;
      core_state_lost_o <= 1'b0;
      instr_nop_o <= 1'b0;
    end else if (clk_en_i) begin
      instr_nop_o <= nop_now & (state_q == lpm_pkg::LPM_ACTIVE || state_q == lpm_pkg::LPM_SUBACTIVE);
      cpu_restart_o <= 1'b0;
      if (state_q == lpm_pkg::LPM_STOP && release_req) begin
        from_stop_q <= 1'b1;
        ram_valid_flag_o <= 1'b1;
      end else if (state_q == lpm_pkg::LPM_WAKE && settle_done) begin
        from_stop_q <= 1'b0;
        cpu_restart_o <= from_stop_q;
        core_state_lost_o <= from_stop_q;
      end else if (state_q == lpm_pkg::LPM_ACTIVE && sleep_req && !nop_now) begin
        core_state_lost_o <= 1'b0;
      end
    end
  end

  // direct select may only be set in subactive and is forced clear in active
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_q <= `LPM_CTRL_RESET;
    end else if (clk_en_i) begin
      if (reg_wr_i && reg_addr_i == `LPM_REG_CTRL) begin
        ctrl_q.sleep_depth_select <= reg_wdata_i[`LPM_CTRL_SLEEP_DEPTH];
        ctrl_q.subclock_halt_select <= reg_wdata_i[`LPM_CTRL_SUB_HALT];
        ctrl_q.low_speed_wake_select <= reg_wdata_i[`LPM_CTRL_LOW_SPEED];
        ctrl_q.direct_wake_select <= reg_wdata_i[`LPM_CTRL_DIRECT] & (state_q == lpm_pkg::LPM_SUBACTIVE);
      end else if (state_q == lpm_pkg::LPM_ACTIVE) begin
        ctrl_q.direct_wake_select <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      reg_rdata_o <= '0;
    end else if (clk_en_i) begin
      reg_rdata_o <= '0;
      if (reg_rd_i) begin
        if (reg_addr_i == `LPM_REG_CTRL) begin
          // bit order follows the write decode, not the struct packing
          reg_rdata_o[`LPM_CTRL_SLEEP_DEPTH] <= ctrl_q.sleep_depth_select;
          reg_rdata_o[`LPM_CTRL_SUB_HALT] <= ctrl_q.subclock_halt_select;
          reg_rdata_o[`LPM_CTRL_LOW_SPEED] <= ctrl_q.low_speed_wake_select;
          reg_rdata_o[`LPM_CTRL_DIRECT] <= ctrl_q.direct_wake_select;
        end else if (reg_addr_i == `LPM_REG_STAT) begin
          reg_rdata_o <= {1'b0, ram_valid_flag_o, state_q};
        end
      end
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  a_standby_entry: assert property (clk_en_i && state_q == lpm_pkg::LPM_ACTIVE && standby_instr_i && !nop_now
    |=> state_q == lpm_pkg::LPM_STANDBY) else $error("standby not entered");
  a_standby_gates: assert property (clk_en_i && state_q == lpm_pkg::LPM_STANDBY
    |-> !gate_o.cpu_clk && gate_o.sys_osc && gate_o.timer_bcd) else $error("standby gating wrong");
  a_standby_exit: assert property (clk_en_i && state_q == lpm_pkg::LPM_STANDBY && irq_request_i
    |=> state_q == lpm_pkg::LPM_ACTIVE) else $error("standby not left on interrupt");
  a_stop_entry: assert property (clk_en_i && state_q == lpm_pkg::LPM_ACTIVE && stop_instr_i && !standby_instr_i
    && !nop_now && !ctrl_q.sleep_depth_select |=> state_q == lpm_pkg::LPM_STOP) else $error("stop not entered");
  a_stop_outputs: assert property (clk_en_i && state_q == lpm_pkg::LPM_STOP
    |-> gate_o.pins_hiz && gate_o.periph_rst && !gate_o.sys_osc
    && gate_o.sub_osc == !ctrl_q.subclock_halt_select) else $error("stop outputs wrong");
  a_stop_hold: assert property (clk_en_i && state_q == lpm_pkg::LPM_STOP && !release_req
    |=> state_q == lpm_pkg::LPM_STOP) else $error("stop left without release");
  a_ram_valid_set: assert property (clk_en_i && state_q == lpm_pkg::LPM_STOP && release_req
    |=> ram_valid_flag_o && state_q == lpm_pkg::LPM_WAKE && gate_o.pins_hiz) else $error("release did not mark ram");
  a_watch_gates: assert property (clk_en_i && state_q == lpm_pkg::LPM_WATCH
    |-> gate_o.timer_a && !gate_o.timer_bcd && !gate_o.serial_irq && !gate_o.adc
    && gate_o.lcd == lcd_on_subclock_i) else $error("watch gating wrong");
  a_nop_stays: assert property (clk_en_i && state_q == lpm_pkg::LPM_ACTIVE && nop_now
    |=> state_q == lpm_pkg::LPM_ACTIVE && instr_nop_o) else $error("blocked instruction slept");
  a_subactive_gates: assert property (clk_en_i && state_q == lpm_pkg::LPM_SUBACTIVE
    |-> !gate_o.sys_osc && !gate_o.adc && gate_o.cpu_clk) else $error("subactive gating wrong");
  a_wake_settle: assert property (clk_en_i && settle_start |=> settle_busy) else $error("settling not started");
  a_release_ignored: assert property (clk_en_i && state_q != lpm_pkg::LPM_STOP
    |=> $stable(ram_valid_flag_o)) else $error("ram valid moved outside stop");
  a_direct_cleared: assert property (clk_en_i && state_q == lpm_pkg::LPM_ACTIVE
    |=> !ctrl_q.direct_wake_select) else $error("direct select kept in active");
  a_watch_timer_wake: assert property (clk_en_i && state_q == lpm_pkg::LPM_WATCH && timer_a_irq_i
    && !ctrl_q.low_speed_wake_select |=> state_q == lpm_pkg::LPM_WAKE && settle_busy) else $error("watch wake wrong");

  c_stop_release: cover property (state_q == lpm_pkg::LPM_STOP ##1 state_q == lpm_pkg::LPM_WAKE);
  c_watch_to_sub: cover property (state_q == lpm_pkg::LPM_WATCH ##1 state_q == lpm_pkg::LPM_SUBACTIVE);
  c_direct_wake: cover property (state_q == lpm_pkg::LPM_SUBACTIVE ##1 state_q == lpm_pkg::LPM_WAKE);
  c_standby_round: cover property (state_q == lpm_pkg::LPM_STANDBY ##1 state_q == lpm_pkg::LPM_ACTIVE);
endmodule : lpm_mode_ctrl
`default_nettype wire

// >>> lpm_defs.svh
// constants for the low-power mode controller
`ifndef LPM_DEFS_SVH
`define LPM_DEFS_SVH
`define LPM_ADDR_W 4
`define LPM_DATA_W 8
`define LPM_REG_CTRL 4'h0
`define LPM_REG_STAT 4'h1
`define LPM_CTRL_SLEEP_DEPTH 0
`define LPM_CTRL_SUB_HALT 1
`define LPM_CTRL_LOW_SPEED 2
`define LPM_CTRL_DIRECT 3
`define LPM_STAT_RAM_VALID 6
`define LPM_CTRL_RESET 4'h0
`define LPM_SETTLE_TIME_NS 122070
`define LPM_CLK_PERIOD_NS 4
`define LPM_SETTLE_CYCLES ((`LPM_SETTLE_TIME_NS + `LPM_CLK_PERIOD_NS - 1) / `LPM_CLK_PERIOD_NS)
`define LPM_CNT_W 16
`endif

// >>> lpm_pkg.sv
// types for the low-power mode controller
package lpm_pkg;
  typedef enum logic [5:0] {
    LPM_ACTIVE    = 6'h01,
    LPM_STANDBY   = 6'h02,
    LPM_STOP      = 6'h04,
    LPM_WATCH     = 6'h08,
    LPM_SUBACTIVE = 6'h10,
    LPM_WAKE      = 6'h20
  } lpm_mode_t;

  typedef struct packed {
    logic sys_osc;
    logic sub_osc;
    logic cpu_clk;
    logic periph_rst;
    logic timer_a;
    logic timer_bcd;
    logic serial;
    logic serial_irq;
    logic adc;
    logic lcd;
    logic pins_hiz;
    logic io_hold;
  } lpm_gate_t;

  typedef struct packed {
    logic sleep_depth_select;
    logic subclock_halt_select;
    logic low_speed_wake_select;
    logic direct_wake_select;
  } lpm_ctrl_t;
endpackage : lpm_pkg

// >>> lpm_settle_timer.sv
// oscillator settling timer: one done pulse a fixed count after start
`timescale 1ns/1ps
`default_nettype none
`include "lpm_defs.svh"
module lpm_settle_timer #(
  parameter int unsigned CYCLES = `LPM_SETTLE_CYCLES
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic start_i,
  output logic busy_o,
  output logic done_o
);
  logic [`LPM_CNT_W-1:0] cnt_q;

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_q <= '0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else if (clk_en_i) begin
      done_o <= 1'b0;
      if (start_i) begin
        cnt_q <= `LPM_CNT_W'(CYCLES - 1);
        busy_o <= 1'b1;
      end else if (busy_o) begin
        if (cnt_q == '0) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end else begin
          cnt_q <= cnt_q - `LPM_CNT_W'(1);
        end
      end
    end
  end
endmodule : lpm_settle_timer
`default_nettype wire

// >>> lpm_partner.sv
// far-side model: board that drives the active-low release and wake pins
`timescale 1ns/1ps
`default_nettype none
module lpm_partner #(
  parameter int unsigned HOLD = 12,
  parameter int unsigned LOW_LEN = 40
) (
  input wire logic clock_i,
  input wire logic release_req_i,
  input wire logic irq_req_i,
  output logic halt_release_pin_n_o,
  output logic ext_irq_zero_pin_n_o
);
  int unsigned rel_cnt = 0;
  int unsigned irq_cnt = 0;
  // release held low for at least one settling period so the oscillator starts
  always @(posedge clock_i) begin
    if (release_req_i) rel_cnt <= HOLD;
    else if (rel_cnt != 0) rel_cnt <= rel_cnt - 1;
  end
  // wake pin held low longer than a frame, or the edge is missed
  always @(posedge clock_i) begin
    if (irq_req_i) irq_cnt <= LOW_LEN;
    else if (irq_cnt != 0) irq_cnt <= irq_cnt - 1;
  end
  assign halt_release_pin_n_o = (rel_cnt == 0);
  assign ext_irq_zero_pin_n_o = (irq_cnt == 0);
endmodule : lpm_partner
`default_nettype wire

// >>> tb.sv
// self-checking testbench for the low-power mode controller
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int unsigned SET = 8;
  localparam int P_REL = 0, P_IRQ = 1, P_TMA = 2, P_EXT_IRQ_ZERO_PIN = 3;
  logic clock_i, reset_i, standby_instr, stp, gie, pend, irq, tma, frm, lcd, rel_req, int_req, wr, rd_s, ce;
  logic rel_n, int_n, nop, rst_o, lost, ramv;
  logic [3:0] addr;
  logic [7:0] wd, rdat, d;
  logic [7:0] fcnt;
  lpm_pkg::lpm_mode_t mode;
  lpm_pkg::lpm_gate_t g;
  int num_errors = 0;
  int comparisons = 0;
  lpm_mode_ctrl #(.SUBACTIVE_EN(1'b1), .SETTLE_CYCLES(SET)) i_dut (.clock_i(clock_i), .reset_i(reset_i),
    .clk_en_i(ce), .standby_instr_i(standby_instr), .stop_instr_i(stp), .global_irq_enable_i(gie),
    .unmasked_irq_pending_i(pend), .irq_request_i(irq), .timer_a_irq_i(tma), .frame_strobe_i(frm),
    .lcd_on_subclock_i(lcd), .ext_irq_zero_pin_n_i(int_n), .halt_release_pin_n_i(rel_n),
    .reg_addr_i(addr), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd_s), .reg_rdata_o(rdat),
    .mode_o(mode), .gate_o(g), .instr_nop_o(nop), .cpu_restart_o(rst_o), .core_state_lost_o(lost),
    .ram_valid_flag_o(ramv));
  lpm_partner #(.HOLD(SET + 4), .LOW_LEN(40)) i_far (.clock_i(clock_i), .release_req_i(rel_req),
    .irq_req_i(int_req), .halt_release_pin_n_o(rel_n), .ext_irq_zero_pin_n_o(int_n));
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  // frame strobe every 16 cycles stands in for the subclock time base
  always @(posedge clock_i) begin
    if (reset_i) fcnt <= 8'h00;
    else fcnt <= fcnt + 8'h01;
    frm <= !reset_i && fcnt[3:0] == 4'hF;
  end
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : tick
  task automatic instr(input bit standby);
    @(posedge clock_i);
    if (standby) standby_instr <= 1'b1;
    else stp <= 1'b1;
    @(posedge clock_i);
    standby_instr <= 1'b0;
    stp <= 1'b0;
    #1;
  endtask : instr
  task automatic pulse_to(input int which);
    @(posedge clock_i);
    case (which)
      P_REL: rel_req <= 1'b1;
      P_IRQ: irq <= 1'b1;
      P_TMA: tma <= 1'b1;
      default: int_req <= 1'b1;
    endcase
    @(posedge clock_i);
    {rel_req, irq, tma, int_req} <= 4'h0;
    #1;
  endtask : pulse_to
  // returns the number of cycles waited; a used-up bound ends the run
  task automatic wait_mode(input lpm_pkg::lpm_mode_t m, input int bound, output int n);
    n = 0;
    while (mode !== m) begin
      if (n == bound) begin
        check("mode wait", 16'(m), 16'(mode));
        complete_run();
      end
      tick(1);
      n++;
    end
  endtask : wait_mode
  task automatic wreg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clock_i);
    addr <= a;
    wd <= v;
    wr <= 1'b1;
    @(posedge clock_i);
    wr <= 1'b0;
    #1;
  endtask : wreg
  task automatic rreg(input logic [3:0] a, output logic [7:0] v);
    @(posedge clock_i);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clock_i);
    rd_s <= 1'b0;
    #1;
    v = rdat;
  endtask : rreg
  task automatic do_reset();
    @(posedge clock_i);
    reset_i <= 1'b1;
    tick(1);
    check("mode in reset", 16'h01, 16'(mode));
    check("gate in reset", 16'h000, 16'(g));
    repeat (7) @(posedge clock_i);
    reset_i <= 1'b0;
    tick(2);
  endtask : do_reset
  task automatic t_reset();
    int n;
    check("gate active", 16'hEFC, 16'(g));
    check("ram valid", 16'h0, 16'(ramv));
    pulse_to(P_REL);
    tick(20);
    check("release in active", 16'h01, 16'(mode));
    check("ram valid", 16'h0, 16'(ramv));
    instr(1'b1);
    check("standby", 16'h02, 16'(mode));
    check("cpu clk", 16'h0, 16'(g.cpu_clk));
    check("osc standby", 16'h3, 16'({g.sys_osc, g.sub_osc}));
    check("timers standby", 16'h3, 16'({g.timer_bcd, g.serial}));
    pulse_to(P_IRQ);
    wait_mode(lpm_pkg::LPM_ACTIVE, 4, n);
    check("no restart", 16'h0, 16'(rst_o));
    $display("test reset and standby done");
  endtask : t_reset
  task automatic t_nop();
    @(posedge clock_i);
    gie <= 1'b0;
    pend <= 1'b1;
    instr(1'b0);
    check("nop flag", 16'h1, 16'(nop));
    check("mode kept", 16'h01, 16'(mode));
    @(posedge clock_i);
    gie <= 1'b1;
    pend <= 1'b0;
    ce <= 1'b0;
    instr(1'b1);
    check("frozen mode", 16'h01, 16'(mode));
    @(posedge clock_i);
    ce <= 1'b1;
    $display("test nop done");
  endtask : t_nop
  task automatic t_stop();
    int n;
    for (int h = 0; h < 2; h++) begin
      wreg(4'h0, {6'h00, h[0], 1'b0});
      instr(1'b0);
      check("stop", 16'h04, 16'(mode));
      check("sub osc", 16'(!h[0]), 16'(g.sub_osc));
      check("stop gates", 16'h3, 16'({g.periph_rst, g.pins_hiz}));
      check("sys osc", 16'h0, 16'(g.sys_osc));
      pulse_to(P_IRQ);
      pulse_to(P_TMA);
      check("stop kept", 16'h04, 16'(mode));
      if (h == 0) begin
        do_reset();
        check("ram valid reset", 16'h0, 16'(ramv));
      end else begin
        pulse_to(P_REL);
        wait_mode(lpm_pkg::LPM_WAKE, 6, n);
        check("ram valid", 16'h1, 16'(ramv));
        check("wake pins", 16'h3, 16'({g.periph_rst, g.pins_hiz}));
        wait_mode(lpm_pkg::LPM_ACTIVE, SET + 4, n);
        check("restart", 16'h1, 16'(rst_o));
        check("state lost", 16'h1, 16'(lost));
      end
    end
    $display("test stop done");
  endtask : t_stop
  task automatic t_watch();
    int n;
    wreg(4'h0, 8'h01);
    instr(1'b0);
    check("watch", 16'h08, 16'(mode));
    check("watch osc", 16'h1, 16'({g.sys_osc, g.sub_osc}));
    check("watch run", 16'h4, 16'({g.timer_a, g.timer_bcd, g.adc}));
    check("serial irq", 16'h0, 16'(g.serial_irq));
    check("watch hold", 16'h2, 16'({g.io_hold, g.pins_hiz}));
    check("state lost cleared", 16'h0, 16'(lost));
    check("lcd sub", 16'h1, 16'(g.lcd));
    pulse_to(P_TMA);
    check("wake", 16'h20, 16'(mode));
    wait_mode(lpm_pkg::LPM_ACTIVE, 20, n);
    check("settle cycles", 16'(SET + 1), 16'(n));
    $display("test watch done");
  endtask : t_watch
  task automatic t_sub();
    int n;
    @(posedge clock_i);
    lcd <= 1'b0;
    wreg(4'h0, 8'h05);
    instr(1'b0);
    check("lcd main", 16'h0, 16'(g.lcd));
    pulse_to(P_EXT_IRQ_ZERO_PIN);
    wait_mode(lpm_pkg::LPM_SUBACTIVE, 2 * 16 + SET + 4, n);
    check("sub gates", 16'h1, 16'({g.sys_osc, g.adc, g.cpu_clk}));
    instr(1'b1);
    check("sub to watch", 16'h08, 16'(mode));
    pulse_to(P_TMA);
    wait_mode(lpm_pkg::LPM_SUBACTIVE, SET + 4, n);
    wreg(4'h0, 8'h09);
    instr(1'b0);
    wait_mode(lpm_pkg::LPM_ACTIVE, SET + 20, n);
    rreg(4'h0, d);
    check("direct cleared", 16'h0, 16'(d[3]));
    rreg(4'h1, d);
    check("status", 16'h41, 16'(d));
    rreg(4'h7, d);
    check("unmapped", 16'h00, 16'(d));
    tick(1);
    check("rdata idle", 16'h00, 16'(rdat));
    instr(1'b1);
    do_reset();
    check("reset from standby", 16'h01, 16'(mode));
    check("ram valid cleared", 16'h0, 16'(ramv));
    $display("test subactive and registers done");
  endtask : t_sub
  initial begin
    {standby_instr, stp, pend, irq, tma, rel_req, int_req, wr, rd_s} = '0;
    ce = 1'b1;
    gie = 1'b1;
    lcd = 1'b1;
    addr = 4'h0;
    wd = 8'h00;
    reset_i = 1'b1;
    repeat (8) @(posedge clock_i);
    reset_i <= 1'b0;
    tick(2);
    t_reset();
    t_nop();
    t_stop();
    t_watch();
    t_sub();
    complete_run();
  end
endmodule : tb
`default_nettype wire
